// ---- core/serial_irq_defs.svh ----
`ifndef SERIAL_IRQ_DEFS_SVH
`define SERIAL_IRQ_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_RX_ERR_IE 8'h00
`define OFS_FRAME_IE 8'h04
`define OFS_SA_LOW 8'h08
`define OFS_SA_HIGH 8'h0C
`define OFS_MODE_CTRL 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_CLEAR 8'h18
`define OFS_IRQ_ENABLE 8'h1C

// ****************************************
// field positions
// ****************************************
`define BIT_RX_OVERRUN_FLAG_EN 3
`define BIT_CRC_EN 2
`define BIT_EOM_EN 7
`define MODE_LSB 0
`define MODE_MSB 1
`define SYNC_LSB 2
`define SYNC_MSB 3
`define ACHK_LSB 4
`define ACHK_MSB 5
`define EVT_RX_OVERRUN_FLAG 0
`define EVT_CRC 1
`define EVT_EOM 2
`define EVT_SUMMARY 3

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define RST_EVT 3'h0

`endif

// ---- core/serial_irq_pkg.sv ----
package serial_irq_pkg;

    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_BYTE_SYNC,
        MODE_BIT_SYNC,
        MODE_SPARE
    } chan_mode_type;

    typedef enum logic [1:0] {
        SYNC_MONO,
        SYNC_BI,
        SYNC_EXTERNAL,
        SYNC_SPARE
    } sync_mode_type;

    typedef enum logic [1:0] {
        ACHK_NONE,
        ACHK_SINGLE1,
        ACHK_SINGLE2,
        ACHK_DUAL
    } addr_check_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic rx_overrun_flag_en;
        logic crc_en;
        logic eom_en;
        logic [7:0] sa_low;
        logic [7:0] sa_high;
        chan_mode_type mode;
        sync_mode_type sync_mode;
        addr_check_type addr_chk;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic irq;
        logic summary;
        logic [15:0] tx_syn;
        logic tx_syn_valid;
        logic tx_syn_wide;
        logic [15:0] rx_syn;
        logic rx_syn_valid;
        logic rx_syn_wide;
        logic [15:0] addr;
        logic addr_low_used;
        logic addr_high_used;
    } regs_state_type;

endpackage

// ---- core/serial_irq_regs.sv ----
`timescale 1ns/100ps
`include "serial_irq_defs.svh"

// Functional notes
// R1 - In every mode an overrun flag with its enable set raises the receive summary, and never with the enable clear.
// R2 - In byte and bit synchronous modes a CRC error flag with its enable set raises the receive summary.
// R3 - In asynchronous mode the CRC error enable reads as zero and software writes zero to it.
// R4 - Bits 1-0 of the receive error enable and bits 6-0 of the frame enable read zero and are written zero.
// R5 - Only in bit synchronous mode a frame end flag with bit 7 enable raises the summary; elsewhere bit 7 reads zero.
// R6 - In mono-sync mode the low sync byte is the receive SYN character.
// R7 - In bi-sync mode the low sync byte is bits 7-0 of the 16-bit SYN pattern for both directions.
// R8 - In bi-sync mode the high sync byte is bits 15-8 of the 16-bit SYN pattern for both directions.
// R9 - In mono-sync and external-sync modes the high sync byte is the transmitted SYN character.
// R10 - The low byte is unused in asynchronous and external-sync modes, the high byte in asynchronous mode.
// R11 - In HDLC with no address check both sync bytes are unused.
// R12 - In HDLC the low byte is address bits 7-0 for single-1 and dual checking and unused for single-2.
// R13 - In HDLC the high byte is address bits 15-8 for single-2 and dual checking and unused for single-1.
// R14 - In bit synchronous mode the sync bytes are never transmitted; software puts address octets in the buffer.
// R15 - Software puts the first octet of a two-octet pattern in the low byte and the second in the high byte.
// R16 - An interrupt request goes out only while a status bit and its enable are both one.
// R17 - The sync bytes are plain reset-cleared read/write storage feeding the steering logic, whose outputs are registered.
module serial_irq_regs
    import serial_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_overrun_flag,
    input wire logic crc_error_flag,
    input wire logic frame_end_flag,
    output logic rx_interrupt_summary,
    output logic irq,
    output logic [15:0] tx_syn_pattern,
    output logic tx_syn_valid,
    output logic tx_syn_wide,
    output logic [15:0] rx_syn_pattern,
    output logic rx_syn_valid,
    output logic rx_syn_wide,
    output logic [15:0] station_addr,
    output logic station_addr_low_used,
    output logic station_addr_high_used
);

    // ****************************************
    // state
    // ****************************************
    regs_state_type state_r;
    regs_state_type state_nxt;

    logic access;
    logic wr_commit;
    logic lane0;
    logic [7:0] wbyte;
    logic rx_overrun_flag_hit;
    logic crc_hit;
    logic eom_hit;
    logic [2:0] hits;
    logic [2:0] clr_mask;
    logic [7:0] rx_err_ie_view;
    logic [7:0] frame_ie_view;
    logic [7:0] mode_view;
    logic [15:0] sel_tx_syn;
    logic sel_tx_valid;
    logic sel_tx_wide;
    logic [15:0] sel_rx_syn;
    logic sel_rx_valid;
    logic sel_rx_wide;
    logic [15:0] sel_addr;
    logic sel_low_used;
    logic sel_high_used;

    // ****************************************
    // sync/address steering
    // ****************************************
    sync_addr_select u_select (
        .mode(state_r.mode),
        .sync_mode(state_r.sync_mode),
        .addr_chk(state_r.addr_chk),
        .sa_low(state_r.sa_low),
        .sa_high(state_r.sa_high),
        .tx_syn(sel_tx_syn),
        .tx_syn_valid(sel_tx_valid),
        .tx_syn_wide(sel_tx_wide),
        .rx_syn(sel_rx_syn),
        .rx_syn_valid(sel_rx_valid),
        .rx_syn_wide(sel_rx_wide),
        .addr(sel_addr),
        .addr_low_used(sel_low_used),
        .addr_high_used(sel_high_used)
    );

    // ****************************************
    // bus decode helpers
    // ****************************************
    assign access = wb_cyc_i & wb_stb_i;
    assign wr_commit = access & wb_we_i & state_r.ack;
    assign lane0 = wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    // ****************************************
    // interrupt conditions
    // ****************************************
    always_comb begin
        rx_overrun_flag_hit = rx_overrun_flag & state_r.rx_overrun_flag_en; // R1
        crc_hit = crc_error_flag & state_r.crc_en
            & (state_r.mode != MODE_ASYNC); // R2
        eom_hit = frame_end_flag & state_r.eom_en
            & (state_r.mode == MODE_BIT_SYNC); // R5
        hits = 3'h0;
        hits[`EVT_RX_OVERRUN_FLAG] = rx_overrun_flag_hit;
        hits[`EVT_CRC] = crc_hit;
        hits[`EVT_EOM] = eom_hit;
    end

    // ****************************************
    // read views with reserved bits at zero
    // ****************************************
    always_comb begin
        rx_err_ie_view = 8'h00; // R4
        rx_err_ie_view[`BIT_RX_OVERRUN_FLAG_EN] = state_r.rx_overrun_flag_en;
        rx_err_ie_view[`BIT_CRC_EN] = state_r.crc_en
            & (state_r.mode != MODE_ASYNC); // R3
        frame_ie_view = 8'h00; // R4
        frame_ie_view[`BIT_EOM_EN] = state_r.eom_en
            & (state_r.mode == MODE_BIT_SYNC); // R5
        mode_view = 8'h00;
        mode_view[`MODE_MSB:`MODE_LSB] = state_r.mode;
        mode_view[`SYNC_MSB:`SYNC_LSB] = state_r.sync_mode;
        mode_view[`ACHK_MSB:`ACHK_LSB] = state_r.addr_chk;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        clr_mask = 3'h0;

        // one wait state, ack drops the cycle after it rose
        state_nxt.ack = access & ~state_r.ack;

        // read data captured together with ack
        if (access & ~state_r.ack) begin
            state_nxt.dat = `RST_WORD;
            case (wb_adr_i)
                `OFS_RX_ERR_IE: begin
                    state_nxt.dat[7:0] = rx_err_ie_view;
                end
                `OFS_FRAME_IE: begin
                    state_nxt.dat[7:0] = frame_ie_view;
                end
                `OFS_SA_LOW: begin
                    state_nxt.dat[7:0] = state_r.sa_low;
                end
                `OFS_SA_HIGH: begin
                    state_nxt.dat[7:0] = state_r.sa_high;
                end
                `OFS_MODE_CTRL: begin
                    state_nxt.dat[7:0] = mode_view;
                end
                `OFS_IRQ_STATUS: begin
                    state_nxt.dat[2:0] = state_r.irq_stat;
                    state_nxt.dat[`EVT_SUMMARY] = state_r.summary;
                end
                `OFS_IRQ_ENABLE: begin
                    state_nxt.dat[2:0] = state_r.irq_en;
                end
                default: begin
                    state_nxt.dat = `RST_WORD;
                end
            endcase
        end else begin
            state_nxt.dat = `RST_WORD;
        end

        // writes take effect on the edge that sees ack
        if (wr_commit & lane0) begin
            case (wb_adr_i)
                `OFS_RX_ERR_IE: begin
                    state_nxt.rx_overrun_flag_en = wbyte[`BIT_RX_OVERRUN_FLAG_EN];
                    state_nxt.crc_en = wbyte[`BIT_CRC_EN]
                        & (state_r.mode != MODE_ASYNC); // R3
                end
                `OFS_FRAME_IE: begin
                    state_nxt.eom_en = wbyte[`BIT_EOM_EN]
                        & (state_r.mode == MODE_BIT_SYNC); // R5
                end
                `OFS_SA_LOW: begin
                    state_nxt.sa_low = wbyte; // R17
                end
                `OFS_SA_HIGH: begin
                    state_nxt.sa_high = wbyte; // R17
                end
                `OFS_MODE_CTRL: begin
                    state_nxt.mode =
                        chan_mode_type'(wbyte[`MODE_MSB:`MODE_LSB]);
                    state_nxt.sync_mode =
                        sync_mode_type'(wbyte[`SYNC_MSB:`SYNC_LSB]);
                    state_nxt.addr_chk =
                        addr_check_type'(wbyte[`ACHK_MSB:`ACHK_LSB]);
                end
                `OFS_IRQ_CLEAR: begin
                    clr_mask = wbyte[2:0];
                end
                `OFS_IRQ_ENABLE: begin
                    state_nxt.irq_en = wbyte[2:0];
                end
                default: begin
                    clr_mask = 3'h0;
                end
            endcase
        end

        // summary follows flag and enable pairs
        state_nxt.summary = |hits; // R1 R2 R5

        // sticky status, a new event beats a clear
        state_nxt.irq_stat = (state_r.irq_stat & ~clr_mask) | hits;

        // level interrupt from enabled status bits
        state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_en); // R16

        // steered sync/address values registered for output
        state_nxt.tx_syn = sel_tx_syn; // R9 R14
        state_nxt.tx_syn_valid = sel_tx_valid; // R14
        state_nxt.tx_syn_wide = sel_tx_wide;
        state_nxt.rx_syn = sel_rx_syn; // R6
        state_nxt.rx_syn_valid = sel_rx_valid; // R10
        state_nxt.rx_syn_wide = sel_rx_wide;
        state_nxt.addr = sel_addr; // R12 R13
        state_nxt.addr_low_used = sel_low_used; // R11 R12
        state_nxt.addr_high_used = sel_high_used; // R11 R13
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r.ack <= 1'b0;
            state_r.dat <= `RST_WORD;
            state_r.rx_overrun_flag_en <= 1'b0;
            state_r.crc_en <= 1'b0;
            state_r.eom_en <= 1'b0;
            state_r.sa_low <= `RST_BYTE; // R17
            state_r.sa_high <= `RST_BYTE; // R17
            state_r.mode <= MODE_ASYNC;
            state_r.sync_mode <= SYNC_MONO;
            state_r.addr_chk <= ACHK_NONE;
            state_r.irq_stat <= `RST_EVT;
            state_r.irq_en <= `RST_EVT;
            state_r.irq <= 1'b0;
            state_r.summary <= 1'b0;
            state_r.tx_syn <= 16'h0000;
            state_r.tx_syn_valid <= 1'b0;
            state_r.tx_syn_wide <= 1'b0;
            state_r.rx_syn <= 16'h0000;
            state_r.rx_syn_valid <= 1'b0;
            state_r.rx_syn_wide <= 1'b0;
            state_r.addr <= 16'h0000;
            state_r.addr_low_used <= 1'b0;
            state_r.addr_high_used <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_dat_o = state_r.dat;
    assign wb_ack_o = state_r.ack;
    assign rx_interrupt_summary = state_r.summary;
    assign irq = state_r.irq;
    assign tx_syn_pattern = state_r.tx_syn;
    assign tx_syn_valid = state_r.tx_syn_valid;
    assign tx_syn_wide = state_r.tx_syn_wide;
    assign rx_syn_pattern = state_r.rx_syn;
    assign rx_syn_valid = state_r.rx_syn_valid;
    assign rx_syn_wide = state_r.rx_syn_wide;
    assign station_addr = state_r.addr;
    assign station_addr_low_used = state_r.addr_low_used;
    assign station_addr_high_used = state_r.addr_high_used;

endmodule

// ---- core/sync_addr_select.sv ----
`timescale 1ns/100ps

// ****************************************
// steering of the sync/address bytes
// ****************************************
module sync_addr_select
    import serial_irq_pkg::*;
(
    input wire chan_mode_type mode,
    input wire sync_mode_type sync_mode,
    input wire addr_check_type addr_chk,
    input wire logic [7:0] sa_low,
    input wire logic [7:0] sa_high,
    output logic [15:0] tx_syn,
    output logic tx_syn_valid,
    output logic tx_syn_wide,
    output logic [15:0] rx_syn,
    output logic rx_syn_valid,
    output logic rx_syn_wide,
    output logic [15:0] addr,
    output logic addr_low_used,
    output logic addr_high_used
);

    always_comb begin
        tx_syn = 16'h0000;
        tx_syn_valid = 1'b0;
        tx_syn_wide = 1'b0;
        rx_syn = 16'h0000;
        rx_syn_valid = 1'b0;
        rx_syn_wide = 1'b0;
        addr = 16'h0000;
        addr_low_used = 1'b0;
        addr_high_used = 1'b0;
        case (mode)
            MODE_BYTE_SYNC: begin
                case (sync_mode)
                    SYNC_MONO: begin
                        rx_syn = {8'h00, sa_low}; // R6
                        rx_syn_valid = 1'b1;
                        tx_syn = {8'h00, sa_high}; // R9
                        tx_syn_valid = 1'b1;
                    end
                    SYNC_BI: begin
                        rx_syn = {sa_high, sa_low}; // R7 R8
                        rx_syn_valid = 1'b1;
                        rx_syn_wide = 1'b1;
                        tx_syn = {sa_high, sa_low}; // R7 R8
                        tx_syn_valid = 1'b1;
                        tx_syn_wide = 1'b1;
                    end
                    SYNC_EXTERNAL: begin
                        tx_syn = {8'h00, sa_high}; // R9 R10
                        tx_syn_valid = 1'b1;
                    end
                    default: begin
                        tx_syn_valid = 1'b0;
                    end
                endcase
            end
            MODE_BIT_SYNC: begin
                // address only for receive checking, never sent R14
                case (addr_chk)
                    ACHK_SINGLE1: begin
                        addr = {8'h00, sa_low}; // R12 R13
                        addr_low_used = 1'b1;
                    end
                    ACHK_SINGLE2: begin
                        addr = {sa_high, 8'h00}; // R12 R13
                        addr_high_used = 1'b1;
                    end
                    ACHK_DUAL: begin
                        addr = {sa_high, sa_low}; // R12 R13
                        addr_low_used = 1'b1;
                        addr_high_used = 1'b1;
                    end
                    default: begin
                        addr_low_used = 1'b0; // R11
                    end
                endcase
            end
            default: begin
                addr_low_used = 1'b0; // R10
            end
        endcase
    end

endmodule

// ---- verif/serial_irq_regs_properties.sv ----
`timescale 1ns/100ps
`include "serial_irq_defs.svh"

// ****************************************
// port relations of the register block
// ****************************************
module serial_irq_regs_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rx_overrun_flag,
    input wire logic crc_error_flag,
    input wire logic frame_end_flag,
    input wire logic rx_interrupt_summary,
    input wire logic irq,
    input wire logic [15:0] tx_syn_pattern,
    input wire logic tx_syn_valid,
    input wire logic tx_syn_wide,
    input wire logic [15:0] rx_syn_pattern,
    input wire logic rx_syn_valid,
    input wire logic rx_syn_wide,
    input wire logic [15:0] station_addr,
    input wire logic station_addr_low_used,
    input wire logic station_addr_high_used
);
    wire logic any_flag;
    wire logic wr_ack;
    wire logic rd_ack;
    assign any_flag = rx_overrun_flag | crc_error_flag | frame_end_flag;
    assign wr_ack = wb_ack_o & wb_we_i;
    assign rd_ack = wb_ack_o & ~wb_we_i;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next_cycle: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_err_reserved_zero: assert property (
        rd_ack && wb_adr_i == `OFS_RX_ERR_IE |-> wb_dat_o[1:0] == 2'h0)
        else $error("reserved error enable bits read nonzero");
    a_frame_reserved_zero: assert property (
        rd_ack && wb_adr_i == `OFS_FRAME_IE |-> wb_dat_o[6:0] == 7'h00)
        else $error("reserved frame enable bits read nonzero");
    a_quiet_no_summary: assert property (
        !any_flag |=> !rx_interrupt_summary)
        else $error("summary without any flag");
    a_irq_has_cause: assert property ($rose(irq) |->
        $past(any_flag) || $past(wr_ack) || $past(wr_ack, 2))
        else $error("irq rose without flag or write");
    a_bisync_shared: assert property (rx_syn_wide |->
        tx_syn_wide && rx_syn_valid && rx_syn_pattern == tx_syn_pattern)
        else $error("wide syn differs between directions");
    a_narrow_tx_syn: assert property (
        tx_syn_valid && !tx_syn_wide |-> tx_syn_pattern[15:8] == 8'h00)
        else $error("narrow tx syn has upper byte");
    a_addr_low_unused: assert property (
        !station_addr_low_used |-> station_addr[7:0] == 8'h00)
        else $error("unused low address byte nonzero");
    a_addr_high_unused: assert property (
        !station_addr_high_used |-> station_addr[15:8] == 8'h00)
        else $error("unused high address byte nonzero");
    a_hdlc_no_tx_syn: assert property (
        station_addr_low_used || station_addr_high_used |-> !tx_syn_valid)
        else $error("tx syn valid in address mode");
    a_steer_after_write: assert property (
        $changed({tx_syn_pattern, rx_syn_pattern, station_addr})
        |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("steered value changed without write");

    c_write: cover property (wr_ack);
    c_summary: cover property ($rose(rx_interrupt_summary));
    c_irq: cover property ($rose(irq));
    c_wide: cover property (rx_syn_wide);
endmodule

bind serial_irq_regs serial_irq_regs_properties i_serial_irq_regs_properties (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_overrun_flag(rx_overrun_flag),
    .crc_error_flag(crc_error_flag), .frame_end_flag(frame_end_flag),
    .rx_interrupt_summary(rx_interrupt_summary), .irq(irq),
    .tx_syn_pattern(tx_syn_pattern), .tx_syn_valid(tx_syn_valid),
    .tx_syn_wide(tx_syn_wide), .rx_syn_pattern(rx_syn_pattern),
    .rx_syn_valid(rx_syn_valid), .rx_syn_wide(rx_syn_wide),
    .station_addr(station_addr),
    .station_addr_low_used(station_addr_low_used),
    .station_addr_high_used(station_addr_high_used));

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`include "serial_irq_defs.svh"

module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] flg = 3'h0;
    logic summary;
    logic irq;
    logic [15:0] tx_p;
    logic [15:0] rx_p;
    logic [15:0] ad_p;
    logic tv, tw, rv, rw, lu, hu;
    integer mismatches = 0;
    integer num_checks = 0;
    // mode words: async, mono, bi, ext, hdlc none, single1, single2, dual
    logic [7:0] cfg [8] = '{8'h00, 8'h01, 8'h05, 8'h09,
                            8'h02, 8'h12, 8'h22, 8'h32};
    logic [15:0] e_tx [8] = '{16'h0, 16'h00C3, 16'hC35A, 16'h00C3,
                              16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] e_rx [8] = '{16'h0, 16'h005A, 16'hC35A, 16'h0,
                              16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] e_ad [8] = '{16'h0, 16'h0, 16'h0, 16'h0,
                              16'h0, 16'h005A, 16'hC300, 16'hC35A};
    logic [5:0] e_fl [8] = '{6'h00, 6'h28, 6'h3C, 6'h20,
                             6'h00, 6'h02, 6'h01, 6'h03};
    logic [7:0] s_mode [7] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00,
                               8'h01};
    logic [1:0] s_flag [7] = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd1, 2'd2, 2'd2};
    logic s_exp [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    always #25 sys_clk = ~sys_clk;

    serial_irq_regs i_serial_irq_regs (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_overrun_flag(flg[0]),
        .crc_error_flag(flg[1]), .frame_end_flag(flg[2]),
        .rx_interrupt_summary(summary), .irq(irq),
        .tx_syn_pattern(tx_p), .tx_syn_valid(tv), .tx_syn_wide(tw),
        .rx_syn_pattern(rx_p), .rx_syn_valid(rv), .rx_syn_wide(rw),
        .station_addr(ad_p), .station_addr_low_used(lu),
        .station_addr_high_used(hu));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdat = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1, "bus ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] t;
        wb(1'b1, adr, {24'h0, d}, t);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp,
                          input string what);
        logic [31:0] t;
        wb(1'b0, adr, 32'h0, t);
        chk(t, exp, what);
    endtask

    task automatic flag_sum(input logic [1:0] f, input logic exp);
        @(posedge sys_clk);
        flg <= 3'h1 << f;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, summary}, {31'h0, exp}, "summary");
        flg <= 3'h0;
        repeat (2) @(posedge sys_clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset;
        for (int a = 0; a < 8; a++) begin
            if (a != 6) rd_chk(8'(a * 4), 32'h0, "reset value");
        end
        wr(8'h24, 8'hFF);
        rd_chk(8'h24, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic test_reserved;
        wr(`OFS_MODE_CTRL, 8'h02);
        wr(`OFS_RX_ERR_IE, 8'h0C);
        wr(`OFS_FRAME_IE, 8'h80);
        rd_chk(`OFS_RX_ERR_IE, 32'h0C, "bit error enables");
        rd_chk(`OFS_FRAME_IE, 32'h80, "bit frame enable");
        wr(`OFS_MODE_CTRL, 8'h01);
        rd_chk(`OFS_RX_ERR_IE, 32'h0C, "byte error enables");
        rd_chk(`OFS_FRAME_IE, 32'h00, "byte frame enable");
        wr(`OFS_MODE_CTRL, 8'h00);
        rd_chk(`OFS_RX_ERR_IE, 32'h08, "async error enables");
        rd_chk(`OFS_FRAME_IE, 32'h00, "async frame enable");
        $display("test reserved done");
    endtask

    task automatic test_summary;
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_MODE_CTRL, s_mode[i]);
            flag_sum(s_flag[i], s_exp[i]);
        end
        wr(`OFS_RX_ERR_IE, 8'h04);
        flag_sum(2'd0, 1'b0);
        $display("test summary done");
    endtask

    task automatic test_irq;
        wr(`OFS_MODE_CTRL, 8'h02);
        wr(`OFS_RX_ERR_IE, 8'h0C);
        wr(`OFS_IRQ_ENABLE, 8'h00);
        wr(`OFS_IRQ_CLEAR, 8'h07);
        rd_chk(`OFS_IRQ_STATUS, 32'h0, "status cleared");
        flag_sum(2'd0, 1'b1);
        flag_sum(2'd2, 1'b1);
        rd_chk(`OFS_IRQ_STATUS, 32'h5, "sticky overrun");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`OFS_IRQ_ENABLE, 8'h02);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "irq other enable");
        wr(`OFS_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        wr(`OFS_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd_chk(`OFS_IRQ_STATUS, 32'h4, "status after clear");
        $display("test irq done");
    endtask

    task automatic test_steer;
        wr(`OFS_SA_LOW, 8'h5A);
        wr(`OFS_SA_HIGH, 8'hC3);
        rd_chk(`OFS_SA_LOW, 32'h5A, "low byte");
        rd_chk(`OFS_SA_HIGH, 32'hC3, "high byte");
        for (int i = 0; i < 8; i++) begin
            wr(`OFS_MODE_CTRL, cfg[i]);
            repeat (3) @(posedge sys_clk);
            chk({16'h0, tx_p}, {16'h0, e_tx[i]}, "tx syn");
            chk({16'h0, rx_p}, {16'h0, e_rx[i]}, "rx syn");
            chk({16'h0, ad_p}, {16'h0, e_ad[i]}, "address");
            chk({26'h0, tv, tw, rv, rw, lu, hu}, {26'h0, e_fl[i]},
                "use flags");
        end
        $display("test steer done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_reserved();
        test_summary();
        test_irq();
        test_steer();
        complete_run();
    end
endmodule
